// ---- rtl/rsd_edge_sync.sv ----
// Two-flop synchroniser with rising edge detector.
`timescale 1ns/1ps
module rsd_edge_sync
	import rsd_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic raw_i,
	rsd_evt_if.src    evt
);

	logic meta_r;
	logic sync_r;
	logic last_r;
	logic rise_r;

	// ------------------------------------------------------------
	// Synchroniser and edge detect
	// ------------------------------------------------------------
	// Synchronise then detect.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
			last_r <= 1'h0;
			rise_r <= 1'h0;
		end else begin
			meta_r <= raw_i;
			sync_r <= meta_r;
			last_r <= sync_r;
			rise_r <= sync_r & ~last_r;
		end
	end

	assign evt.rise = rise_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_single_rise;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rise_r |=> !rise_r;
	endproperty
	a_single_rise: assert property (p_single_rise)
		else $error("Edge pulse lasted more than one cycle.");

endmodule // rsd_edge_sync

// ---- rtl/rsd_evt_if.sv ----
// Event carrier between the input synchroniser and the detector.
`timescale 1ns/1ps
interface rsd_evt_if;
	logic rise;
	modport src (output rise);
	modport dst (input  rise);
endinterface

// ---- rtl/rsd_pkg.sv ----
// Constants and types for the ribbon stall detector.
//
// Overview of operation
// - Count carriage steps, pulse at every 256.
// - Ribbon pulse clears both counter stages.
// - Clearing keeps chain output idle high.
// - Full count gives low pulse, sets latch.
// - Set latch drives inhibit low until reset.
// - Inhibit level readable via status port five.
// - Restore high without a chain pulse resets latch, inhibit goes high.
package rsd_pkg;

	// ------------------------------------------------------------
	// Counter chain
	// ------------------------------------------------------------
	localparam int          STAGE_W     = 4;
	localparam int          CHAIN_COUNT = 256;
	localparam int          STATUS_PORT = 5;
	localparam logic        CHAIN_IDLE  = 1'h1;
	localparam logic        CHAIN_FIRE  = 1'h0;
	localparam logic        INHIBIT_OFF = 1'h1;

	// ------------------------------------------------------------
	// Stall latch states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RSD_ST_RUN   = 2'h1,
		RSD_ST_STALL = 2'h2
	} rsd_state_e;

	localparam int          RUN_BIT     = 0;

endpackage

// ---- rtl/rsd_top.sv ----
// Ribbon stall detector: counter chain, stall latch and inhibit output.
`timescale 1ns/1ps
module rsd_top
	import rsd_pkg::*;
#(
	parameter int W = STAGE_W
) (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic carriage_step_a_i,
	input  wire logic ribbon_pulse_in_i,
	input  wire logic restore_i,
	output logic      chain_out_n_o,
	output logic      ribbon_stall_inhibit_n_o
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam logic [W-1:0] STAGE_MAX  = {W{1'h1}};
	localparam logic [W-1:0] STAGE_ZERO = {W{1'h0}};

	rsd_evt_if car_evt ();
	rsd_evt_if rib_evt ();

	logic [W-1:0] lo_r;
	logic [W-1:0] lo_nxt;
	logic [W-1:0] hi_r;
	logic [W-1:0] hi_nxt;
	logic         chain_out_n_r;
	logic         chain_out_n_nxt;
	rsd_state_e   state_r;
	rsd_state_e   state_nxt;
	logic         car_step;
	logic         rib_clr;
	logic         lo_carry;
	logic         full;

	// Returns the stage value after one step.
	function automatic logic [W-1:0] stage_step(input logic [W-1:0] v);
		stage_step = v + {{(W-1){1'h0}}, 1'h1};
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	rsd_edge_sync u_car_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.raw_i      (carriage_step_a_i),
		.evt        (car_evt.src)
	);

	rsd_edge_sync u_rib_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.raw_i      (ribbon_pulse_in_i),
		.evt        (rib_evt.src)
	);

	assign car_step = car_evt.rise;
	assign rib_clr  = rib_evt.rise;

	// ------------------------------------------------------------
	// Counter chain
	// ------------------------------------------------------------
	assign lo_carry = (lo_r == STAGE_MAX);
	assign full     = lo_carry && (hi_r == STAGE_MAX);

	always_comb begin
		lo_nxt          = lo_r;
		hi_nxt          = hi_r;
		chain_out_n_nxt = CHAIN_IDLE;
		if (rib_clr) begin
			lo_nxt = STAGE_ZERO;
			hi_nxt = STAGE_ZERO;
		end else if (car_step) begin
			lo_nxt = stage_step(lo_r);
			if (lo_carry) begin
				hi_nxt = stage_step(hi_r);
			end
			if (full) begin
				chain_out_n_nxt = CHAIN_FIRE;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lo_r <= STAGE_ZERO;
			hi_r <= STAGE_ZERO;
		end else begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chain_out_n_r <= CHAIN_IDLE;
		end else begin
			chain_out_n_r <= chain_out_n_nxt;
		end
	end

	// ------------------------------------------------------------
	// Stall latch
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RSD_ST_RUN: begin
				if (chain_out_n_r == CHAIN_FIRE) begin
					state_nxt = RSD_ST_STALL;
				end
			end
			RSD_ST_STALL: begin
				if (restore_i && chain_out_n_r == CHAIN_IDLE) begin
					state_nxt = RSD_ST_RUN;
				end
			end
			default: begin
				state_nxt = RSD_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= RSD_ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign chain_out_n_o = chain_out_n_r;
	assign ribbon_stall_inhibit_n_o = state_r[RUN_BIT];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_count_step;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		car_step && !rib_clr |=> {hi_r, lo_r} == $past({hi_r, lo_r}) + 1'h1;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("Counter chain did not advance on a carriage step.");

	property p_fire_at_full;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		car_step && !rib_clr && full |=> !chain_out_n_r && lo_r == STAGE_ZERO
			&& hi_r == STAGE_ZERO;
	endproperty
	a_fire_at_full: assert property (p_fire_at_full)
		else $error("Chain did not fire and wrap at full count.");

	property p_ribbon_clear;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rib_clr |=> lo_r == STAGE_ZERO && hi_r == STAGE_ZERO;
	endproperty
	a_ribbon_clear: assert property (p_ribbon_clear)
		else $error("Ribbon pulse did not clear the counter chain.");

	property p_idle_on_clear;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rib_clr |=> chain_out_n_r;
	endproperty
	a_idle_on_clear: assert property (p_idle_on_clear)
		else $error("Chain output fired despite a ribbon clear.");

	property p_fire_only_full;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!chain_out_n_r |-> $past(full && car_step && !rib_clr);
	endproperty
	a_fire_only_full: assert property (p_fire_only_full)
		else $error("Chain output fired before the full count.");

	property p_fire_sets;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!chain_out_n_r |=> !ribbon_stall_inhibit_n_o;
	endproperty
	a_fire_sets: assert property (p_fire_sets)
		else $error("Chain pulse did not set the stall latch.");

	property p_hold_inhibit;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!ribbon_stall_inhibit_n_o && !restore_i |=> !ribbon_stall_inhibit_n_o;
	endproperty
	a_hold_inhibit: assert property (p_hold_inhibit)
		else $error("Inhibit released without a restore.");

	property p_status_level;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!$stable(ribbon_stall_inhibit_n_o) |-> $past(!chain_out_n_r || restore_i);
	endproperty
	a_status_level: assert property (p_status_level)
		else $error("Inhibit level changed without a chain pulse or a restore.");

	property p_restore;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		restore_i && chain_out_n_r |=> ribbon_stall_inhibit_n_o;
	endproperty
	a_restore: assert property (p_restore)
		else $error("Restore did not release the inhibit.");

	property p_clear_priority;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rib_clr && car_step |=> lo_r == STAGE_ZERO ##1 chain_out_n_r;
	endproperty
	a_clear_priority: assert property (p_clear_priority)
		else $error("Carriage step beat a simultaneous ribbon clear.");

	c_stall: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!chain_out_n_r ##1 !ribbon_stall_inhibit_n_o);
	c_restore: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!ribbon_stall_inhibit_n_o ##1 ribbon_stall_inhibit_n_o);
	c_clear_mid: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		rib_clr && hi_r != STAGE_ZERO);
	c_set_wins: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!chain_out_n_r && restore_i ##1 !ribbon_stall_inhibit_n_o);

endmodule // rsd_top

// ---- tb/rsd_host_model.sv ----
// Interface board model: status port latch and restore driver.
`timescale 1ns/1ps
module rsd_host_model (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic inhibit_n_i,
	input  wire logic restore_req_i,
	output logic      restore_o,
	output logic      status_stall_n_o
);
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_stall_n_o <= 1'h1;
		end else begin
			status_stall_n_o <= inhibit_n_i;
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			restore_o <= 1'h0;
		end else begin
			restore_o <= restore_req_i;
		end
	end
endmodule // rsd_host_model

// ---- tb/testbench.sv ----
// Self-checking bench for the ribbon stall detector.
`timescale 1ns/1ps
module testbench
	import rsd_pkg::*;
;
	// ----
	// Signals
	// ----
	logic        core_clk_i      = 1'h0;
	logic        rst_n_i         = 1'h0;
	logic        car_r           = 1'h0;
	logic        rib_r           = 1'h0;
	logic        req_r           = 1'h0;
	logic        restore;
	logic        chain_n;
	logic        inhibit_n;
	logic        status_n;
	int          num_errors      = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	int          test_id         = 0;
	int          notes[$];
	logic [31:0] seed            = 32'hDBCE;

	always #2 core_clk_i = ~core_clk_i;

	rsd_top #(.W(STAGE_W)) dut_u (
		.core_clk_i               (core_clk_i),
		.rst_n_i                  (rst_n_i),
		.carriage_step_a_i        (car_r),
		.ribbon_pulse_in_i        (rib_r),
		.restore_i                (restore),
		.chain_out_n_o            (chain_n),
		.ribbon_stall_inhibit_n_o (inhibit_n)
	);

	rsd_host_model host_u (
		.core_clk_i       (core_clk_i),
		.rst_n_i          (rst_n_i),
		.inhibit_n_i      (inhibit_n),
		.restore_req_i    (req_r),
		.restore_o        (restore),
		.status_stall_n_o (status_n)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("Checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic step(input logic rib);
		seed = xs(seed);
		@(posedge core_clk_i);
		car_r <= 1'h1;
		rib_r <= rib;
		repeat (2 + seed[1:0]) @(posedge core_clk_i);
		car_r <= 1'h0;
		rib_r <= 1'h0;
		repeat (2 + seed[3:2]) @(posedge core_clk_i);
	endtask

	task automatic run(input int n, input int rib_every);
		for (int i = 1; i <= n; i++) begin
			if (rib_every == 0 && i % CHAIN_COUNT == 0)
				notes.push_back(test_id);
			step(rib_every != 0 && i % rib_every == 0);
		end
		repeat (8) @(posedge core_clk_i);
	endtask

	task automatic restore_test(input int hold);
		@(posedge core_clk_i);
		req_r <= 1'h1;
		repeat (hold) @(posedge core_clk_i);
		req_r <= 1'h0;
		repeat (3) @(posedge core_clk_i);
		check("inhibit restored", inhibit_n, INHIBIT_OFF); // Latch released.
		check("status restored", status_n, INHIBIT_OFF); // Status follows.
	endtask

	task automatic end_test();
		check("pending pulses", notes.size(), 0); // Pulse delivered.
		$display("Test %0d done", test_id);
	endtask

	// ----
	// Result monitor
	// ----
	always @(posedge core_clk_i) begin
		if (rst_n_i && chain_n === CHAIN_FIRE) begin // Pulse seen.
			if (notes.size() == 0) // Nothing expected.
				check("spurious pulse", 1, 0); // Stays idle.
			else
				check("pulse test", notes.pop_front(), test_id); // Pulse at count.
		end
	end

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			give_verdict();
		end
	end

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		test_id = 1;
		@(posedge core_clk_i);
		check("chain idle", chain_n, CHAIN_IDLE); // Idle after reset.
		check("inhibit idle", inhibit_n, INHIBIT_OFF); // Inactive at reset.
		end_test();
		test_id = 2;
		run(2 * CHAIN_COUNT, 0);
		check("inhibit set", inhibit_n, !INHIBIT_OFF); // Held low.
		check("status set", status_n, !INHIBIT_OFF); // Level captured.
		end_test();
		test_id = 3;
		restore_test(1);
		end_test();
		test_id = 4;
		run(200, 0);
		step(1'h1);
		run(CHAIN_COUNT, 0);
		check("inhibit after clear", inhibit_n, !INHIBIT_OFF); // Count from zero.
		restore_test(3);
		end_test();
		test_id = 5;
		run(3 * CHAIN_COUNT, 100);
		check("inhibit kept off", inhibit_n, INHIBIT_OFF); // Clears prevent stall.
		end_test();
		test_id = 6;
		req_r <= 1'h1;
		step(1'h1);
		run(CHAIN_COUNT, 0);
		req_r <= 1'h0;
		repeat (3) @(posedge core_clk_i);
		check("restore level held", inhibit_n, INHIBIT_OFF); // Level restore.
		check("status after restore", status_n, INHIBIT_OFF); // Status follows.
		end_test();
		give_verdict();
	end
endmodule // testbench
